// ### verilog/regfile_flags.sv
/*
  General register file with sized views, stack pointer tap and
  the arithmetic flag update.
  Assumes the decoder issues one write, two reads and an operation
  request per cycle on the same core clock.
*/
`timescale 1ns/1ps
module regfile_flags
  import regfile_flags_pkg::*;
#(
  parameter int NREGS = REG_COUNT
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register write
  input wire logic wr_en,
  input wire reg_sel_t wr_sel,
  input wire logic [WORD_W-1:0] wr_data,
  // Register reads
  input wire reg_sel_t rd_sel_a,
  input wire reg_sel_t rd_sel_b,
  output logic [WORD_W-1:0] rd_data_a,
  output logic [WORD_W-1:0] rd_data_b,
  // Stack pointer
  output logic [WORD_W-1:0] stack_pointer,
  // Arithmetic
  input wire alu_req_t alu_req,
  output logic [WORD_W-1:0] alu_result,
  output logic alu_done,
  output cc_flags_t condition_code_register
);

  logic [WORD_W-1:0] regs_reg [NREGS];
  logic [WORD_W-1:0] regs_next [NREGS];
  logic [WORD_W-1:0] rd_a_reg, rd_a_next, rd_b_reg, rd_b_next;
  logic [WORD_W-1:0] sp_reg, sp_next, res_reg, res_next;
  logic done_reg, done_next;
  cc_flags_t cc_reg, cc_next;
  logic [WORD_W-1:0] judge_result;
  cc_flags_t judge_flags;

  // Extract a view, right-aligned, zero above
  function automatic logic [WORD_W-1:0] view_read(input logic [WORD_W-1:0] r, input reg_view_t v);
    case (v)
      VIEW_UPPER: view_read = {16'h0000, r[31:16]};
      VIEW_LOWER: view_read = {16'h0000, r[15:0]};
      VIEW_BYTE_HI: view_read = {24'h000000, r[15:8]};
      VIEW_BYTE_LO: view_read = {24'h000000, r[7:0]};
      default: view_read = r;
    endcase
  endfunction : view_read

  // Merge a view into a register, other bits kept
  function automatic logic [WORD_W-1:0] view_write(input logic [WORD_W-1:0] r,
                                                   input reg_view_t v,
                                                   input logic [WORD_W-1:0] d);
    case (v)
      VIEW_UPPER: view_write = {d[15:0], r[15:0]};
      VIEW_LOWER: view_write = {r[31:16], d[15:0]};
      VIEW_BYTE_HI: view_write = {r[31:16], d[7:0], r[7:0]};
      VIEW_BYTE_LO: view_write = {r[31:8], d[7:0]};
      default: view_write = d;
    endcase
  endfunction : view_write

  overflow_judge judge (
    .kind(alu_req.kind),
    .size(alu_req.size),
    .a(alu_req.a),
    .b(alu_req.b),
    .result(judge_result),
    .flags(judge_flags)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NREGS; gi++) begin : g_reg
      always_comb begin
        regs_next[gi] = regs_reg[gi];
        if (wr_en && (wr_sel.idx == REG_IDX_W'(gi))) begin
          regs_next[gi] = view_write(regs_reg[gi], wr_sel.view, wr_data);
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          regs_reg[gi] <= REG_RESET_VALUE;
        end else begin
          regs_reg[gi] <= regs_next[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    // Reads see the file as it stood before this cycle's write
    rd_a_next = view_read(regs_reg[rd_sel_a.idx], rd_sel_a.view);
    rd_b_next = view_read(regs_reg[rd_sel_b.idx], rd_sel_b.view);
    // Same storage as register seven, so any view write moves it
    sp_next = regs_next[STACK_REG_IDX];
    res_next = res_reg;
    cc_next = cc_reg;
    done_next = 1'b0;
    if (alu_req.start) begin
      // One update at the end of the operation; idle cycles hold
      res_next = judge_result;
      cc_next = judge_flags;
      done_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rd_a_reg <= REG_RESET_VALUE;
      rd_b_reg <= REG_RESET_VALUE;
      sp_reg <= REG_RESET_VALUE;
      res_reg <= REG_RESET_VALUE;
      cc_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      rd_a_reg <= rd_a_next;
      rd_b_reg <= rd_b_next;
      sp_reg <= sp_next;
      res_reg <= res_next;
      cc_reg <= cc_next;
      done_reg <= done_next;
    end
  end

  assign rd_data_a = rd_a_reg;
  assign rd_data_b = rd_b_reg;
  assign stack_pointer = sp_reg;
  assign alu_result = res_reg;
  assign alu_done = done_reg;
  assign condition_code_register = cc_reg;

endmodule : regfile_flags

// ### shared/regfile_flags_pkg.sv
/*
  Constants and types for the general register file with its
  overflow and carry flag judge.
  Assumes one core clock and a synchronous active-low reset.
*/
package regfile_flags_pkg;

  localparam int REG_COUNT = 8;
  localparam int REG_IDX_W = 3;
  localparam int WORD_W = 32;
  localparam logic [REG_IDX_W-1:0] STACK_REG_IDX = 3'h7;
  localparam logic [WORD_W-1:0] REG_RESET_VALUE = 32'h00000000;

  // Signed bounds per operand size, plus unsigned byte bounds
  localparam logic [7:0] BYTE_SMAX = 8'h7f;
  localparam logic [7:0] BYTE_SMIN = 8'h80;
  localparam logic [15:0] WORD_SMAX = 16'h7fff;
  localparam logic [15:0] WORD_SMIN = 16'h8000;
  localparam logic [31:0] LONG_SMAX = 32'h7fffffff;
  localparam logic [31:0] LONG_SMIN = 32'h80000000;
  localparam logic [7:0] BYTE_UMAX = 8'hff;
  localparam logic [7:0] BYTE_UMIN = 8'h00;

  // Condition code bit positions of the two flags
  localparam int CC_CARRY_BIT = 0;
  localparam int CC_OVFL_BIT = 1;

  typedef enum logic [2:0] {
    VIEW_LONG = 3'h0,
    VIEW_UPPER = 3'h1,
    VIEW_LOWER = 3'h3,
    VIEW_BYTE_HI = 3'h2,
    VIEW_BYTE_LO = 3'h6
  } reg_view_t;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h3
  } op_size_t;

  typedef enum logic [1:0] {
    OP_ADD = 2'h0,
    OP_SUB = 2'h1
  } op_kind_t;

  typedef struct packed {
    logic [REG_IDX_W-1:0] idx;
    reg_view_t view;
  } reg_sel_t;

  typedef struct packed {
    logic start;
    op_kind_t kind;
    op_size_t size;
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
  } alu_req_t;

  typedef struct packed {
    logic overflow;
    logic carry;
  } cc_flags_t;

endpackage : regfile_flags_pkg

// ### verilog/overflow_judge.sv
/*
  Combinational judge of result and flags for add and subtract.
  Assumes operands are already right-aligned to the selected size.
*/
`timescale 1ns/1ps
module overflow_judge
  import regfile_flags_pkg::*;
(
  // Operation
  input wire op_kind_t kind,
  input wire op_size_t size,
  input wire logic [WORD_W-1:0] a,
  input wire logic [WORD_W-1:0] b,
  // Outcome
  output logic [WORD_W-1:0] result,
  output cc_flags_t flags
);

  function automatic logic top_bit(input logic [WORD_W-1:0] v, input op_size_t s);
    case (s)
      SIZE_BYTE: top_bit = v[7];
      SIZE_WORD: top_bit = v[15];
      default: top_bit = v[31];
    endcase
  endfunction : top_bit

  function automatic logic carry_out(input logic [WORD_W:0] w, input logic [WORD_W-1:0] x,
                                     input logic [WORD_W-1:0] y, input op_size_t s);
    logic [WORD_W-1:0] cin;
    cin = w[WORD_W-1:0] ^ x ^ y;
    case (s)
      SIZE_BYTE: carry_out = cin[8];
      SIZE_WORD: carry_out = cin[16];
      default: carry_out = w[WORD_W];
    endcase
  endfunction : carry_out

  logic [WORD_W:0] wide;
  logic [WORD_W-1:0] b_eff;
  logic sa;
  logic sb;
  logic sr;

  always_comb begin
    b_eff = (kind == OP_SUB) ? ~b : b;
    wide = {1'b0, a} + {1'b0, b_eff} + {{WORD_W{1'b0}}, (kind == OP_SUB)};
    result = wide[WORD_W-1:0];
    // Flags judged at the top bit of the chosen size only
    sa = top_bit(a, size);
    sb = top_bit(b_eff, size);
    sr = top_bit(result, size);
    // Same-sign operands giving other-sign result: out of signed range
    flags.overflow = (sa == sb) && (sr != sa);
    // Carry out above max on add, borrow below zero on subtract
    flags.carry = carry_out(wide, a, b_eff, size) ^ (kind == OP_SUB);
  end

endmodule : overflow_judge

// ### sim/regfile_flags_checker.sv
/* Flag, view and stack pointer checks for regfile_flags.
   Sees only the top ports; bound in below the module. */
`timescale 1ns/1ps
module regfile_flags_checker
  import regfile_flags_pkg::*;
#(parameter int NREGS = REG_COUNT)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Requests
  input wire logic wr_en,
  input wire reg_sel_t wr_sel,
  input wire logic [WORD_W-1:0] wr_data,
  input wire reg_sel_t rd_sel_a,
  input wire alu_req_t alu_req,
  // Answers
  input wire logic [WORD_W-1:0] rd_data_a,
  input wire logic [WORD_W-1:0] stack_pointer,
  input wire logic alu_done,
  input wire cc_flags_t condition_code_register
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic st, sub;
  logic [WORD_W-1:0] a, bb;
  logic [WORD_W:0] s;
  logic [8:0] s8;
  logic [2:0] v;
  assign st = alu_req.start;
  assign sub = alu_req.kind == OP_SUB;
  assign a = alu_req.a;
  // Subtract as add of inverted b plus one; borrow is the missing carry
  assign bb = alu_req.b ^ {WORD_W{sub}};
  assign s = a + bb + sub;
  assign s8 = a[7:0] + bb[7:0] + sub;
  assign v[0] = (a[7] == bb[7]) && (s[7] != a[7]);
  assign v[1] = (a[15] == bb[15]) && (s[15] != a[15]);
  assign v[2] = (a[31] == bb[31]) && (s[31] != a[31]);
  property p_done; 1 |=> alu_done == $past(st); endproperty
  property p_hold; !st |=> $stable(condition_code_register); endproperty
  property p_sp;
    wr_en && wr_sel.idx == STACK_REG_IDX && wr_sel.view == VIEW_LONG
      |=> stack_pointer == $past(wr_data);
  endproperty
  property p_rd;
    wr_en && wr_sel.view == VIEW_BYTE_LO ##1 !wr_en && rd_sel_a == $past(wr_sel)
      |=> rd_data_a == {24'h0, $past(wr_data[7:0], 2)};
  endproperty
  property p_cb;
    st && alu_req.size == SIZE_BYTE |=> condition_code_register.carry == $past(s8[8] ^ sub);
  endproperty
  property p_vb;
    st && alu_req.size == SIZE_BYTE |=> condition_code_register.overflow == $past(v[0]);
  endproperty
  property p_vw;
    st && alu_req.size == SIZE_WORD |=> condition_code_register.overflow == $past(v[1]);
  endproperty
  property p_vl;
    st && alu_req.size == SIZE_LONG |=> condition_code_register.overflow == $past(v[2]);
  endproperty
  a_done: assert property (p_done) else $error("done pulse misplaced");
  a_hold: assert property (p_hold) else $error("flags moved without op");
  a_sp: assert property (p_sp) else $error("stack pointer stale");
  a_rd: assert property (p_rd) else $error("byte view read wrong");
  a_cb: assert property (p_cb) else $error("byte carry wrong");
  a_vb: assert property (p_vb) else $error("byte overflow wrong");
  a_vw: assert property (p_vw) else $error("word overflow wrong");
  a_vl: assert property (p_vl) else $error("long overflow wrong");
  c_vb: cover property (st && alu_req.size == SIZE_BYTE && v[0]);
  c_vl: cover property (st && alu_req.size == SIZE_LONG && v[2]);
  c_sp: cover property (wr_en && wr_sel.idx == STACK_REG_IDX);
endmodule : regfile_flags_checker

bind regfile_flags regfile_flags_checker #(.NREGS(NREGS)) i_chk (.ref_clk, .reset_n, .wr_en,
  .wr_sel, .wr_data, .rd_sel_a, .alu_req, .rd_data_a, .stack_pointer, .alu_done,
  .condition_code_register);

// ### sim/regfile_flags_tb.sv
/* Self-checking bench for regfile_flags: views, stack pointer, flags.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/1ps
module regfile_flags_tb;
  import regfile_flags_pkg::*;
  logic ref_clk, reset_n, wr_en, alu_done;
  reg_sel_t wr_sel, rd_sel_a, rd_sel_b;
  logic [WORD_W-1:0] wr_data, rd_data_a, rd_data_b, stack_pointer, alu_result;
  alu_req_t alu_req;
  cc_flags_t condition_code_register;
  int errors, samples_checked;
  regfile_flags i_dut (.ref_clk, .reset_n, .wr_en, .wr_sel, .wr_data, .rd_sel_a,
    .rd_sel_b, .rd_data_a, .rd_data_b, .stack_pointer, .alu_req, .alu_result,
    .alu_done, .condition_code_register);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask : step
  // Write enable stays up after a write; back-to-back writes never toggle it
  task automatic wr(input logic [2:0] i, input reg_view_t w, input logic [WORD_W-1:0] d);
    wr_en = 1'b1;
    wr_sel = '{i, w};
    wr_data = d;
    step();
  endtask : wr
  task automatic rd(input logic [2:0] i, input reg_view_t w, input logic [WORD_W-1:0] e);
    wr_en = 1'b0;
    rd_sel_a = '{i, w};
    rd_sel_b = '{i, w};
    step();
    chk(rd_data_a, e);
    chk(rd_data_b, e);
  endtask : rd
  // Flags must still hold in the cycle the done pulse drops
  task automatic op(input op_kind_t k, input op_size_t z, input logic [31:0] a, b,
                    input logic [1:0] f, input logic [31:0] r);
    alu_req = '{1'b1, k, z, a, b};
    step();
    alu_req.start = 1'b0;
    chk(alu_done, 1);
    chk(condition_code_register, f);
    chk(alu_result, r);
    step();
    chk(alu_done, 0);
    chk(condition_code_register, f);
  endtask : op
  task automatic t_views;
    rd(3, VIEW_LONG, 32'h0);
    wr(3, VIEW_LONG, 32'h11223344);
    wr(3, VIEW_BYTE_HI, 32'haa);
    wr(3, VIEW_UPPER, 32'h5566);
    wr(4, VIEW_BYTE_LO, 32'h77);
    rd(3, VIEW_LONG, 32'h5566aa44);
    rd(3, VIEW_LOWER, 32'haa44);
    rd(3, VIEW_BYTE_HI, 32'haa);
    rd(3, VIEW_BYTE_LO, 32'h44);
    rd(3, VIEW_UPPER, 32'h5566);
    rd(4, VIEW_LONG, 32'h77);
    wr(5, VIEW_BYTE_LO, 32'h5a);
    rd(5, VIEW_BYTE_LO, 32'h5a);
    $display("views test done");
  endtask : t_views
  task automatic t_sp;
    wr(7, VIEW_LONG, 32'hfffe);
    chk(stack_pointer, 32'hfffe);
    wr(7, VIEW_BYTE_LO, 32'h10);
    chk(stack_pointer, 32'hff10);
    rd(7, VIEW_LONG, 32'hff10);
    $display("stack pointer test done");
  endtask : t_sp
  task automatic t_flags;
    op(OP_ADD, SIZE_BYTE, 32'h7f, 32'h01, 2'b10, 32'h80);
    op(OP_ADD, SIZE_BYTE, 32'h80, 32'hff, 2'b11, 32'h17f);
    op(OP_SUB, SIZE_BYTE, 32'h00, 32'h01, 2'b01, 32'hffffffff);
    op(OP_ADD, SIZE_BYTE, 32'hff, 32'h01, 2'b01, 32'h100);
    op(OP_ADD, SIZE_WORD, 32'h7fff, 32'h1, 2'b10, 32'h8000);
    op(OP_SUB, SIZE_WORD, 32'h8000, 32'h1, 2'b10, 32'h7fff);
    op(OP_ADD, SIZE_LONG, 32'h7fffffff, 32'h1, 2'b10, 32'h80000000);
    op(OP_SUB, SIZE_LONG, 32'h80000000, 32'h1, 2'b10, 32'h7fffffff);
    op(OP_ADD, SIZE_WORD, 32'h7f, 32'h1, 2'b00, 32'h80);
    op(OP_ADD, SIZE_LONG, 32'hffff, 32'h1, 2'b00, 32'h10000);
    $display("flags test done");
  endtask : t_flags
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #20us;
    errors++;
    wrap_up();
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    wr_en = 1'b0;
    wr_sel = '0;
    wr_data = '0;
    rd_sel_a = '0;
    rd_sel_b = '0;
    alu_req = '0;
    repeat (5) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    t_views();
    t_sp();
    t_flags();
    wrap_up();
  end
endmodule : regfile_flags_tb
